// [bench/gms_checker.sv]
`timescale 1ns/10ps
module gms_checker import gms_pkg::*; (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Watched ports
  input wire gms_pins_t pins,
  input wire logic led_stop,
  input wire logic led_manual,
  input wire logic led_test,
  input wire logic led_auto,
  input wire logic fuel_relay,
  input wire logic starter,
  input wire logic gen_load,
  input wire logic speed_detect,
  input wire logic fault_holdoff,
  input wire logic engine_at_rest,
  input wire logic config_allowed,
  input wire logic fail_to_start,
  input wire logic fail_to_stop
);
  logic [3:0] leds;
  assign leds = {led_stop, led_manual, led_test, led_auto};
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  property p_one_mode;
    $onehot(leds);
  endproperty
  a_one_mode: assert property (p_one_mode)
    else $error("mode indicators not one-hot");
  // Lock goes through the same two-stage sync as the buttons
  property p_lock;
    pins.panel_lock && $past(pins.panel_lock) && $past(pins.panel_lock, 2) |=> $stable(leds);
  endproperty
  a_lock: assert property (p_lock)
    else $error("mode changed while panel locked");
  property p_stop_seq;
    $rose(led_stop) |-> ##[1:2] !gen_load ##[0:1] !fuel_relay;
  endproperty
  a_stop_seq: assert property (p_stop_seq)
    else $error("stop press did not drop load and fuel");
  property p_load_first;
    $rose(led_stop) && gen_load |-> fuel_relay;
  endproperty
  a_load_first: assert property (p_load_first)
    else $error("engine stopped before load removed");
  property p_stop_idle;
    led_stop && $past(led_stop, 2) |-> !starter && !fuel_relay;
  endproperty
  a_stop_idle: assert property (p_stop_idle)
    else $error("engine driven in stop mode");
  property p_crank;
    starter |-> fuel_relay;
  endproperty
  a_crank: assert property (p_crank)
    else $error("starter without fuel relay");
  property p_fts;
    $rose(fail_to_start) |-> !starter && !fuel_relay;
  endproperty
  a_fts: assert property (p_fts)
    else $error("fail to start with engine still driven");
  property p_holdoff;
    $fell(starter) && $past(speed_detect) && !led_stop |-> fault_holdoff;
  endproperty
  a_holdoff: assert property (p_holdoff)
    else $error("no fault hold-off after firing");
  property p_avail;
    gen_load |-> $past(pins.gen_avail, 2);
  endproperty
  a_avail: assert property (p_avail)
    else $error("load taken without generator available");
  property p_config;
    config_allowed |-> engine_at_rest && led_stop;
  endproperty
  a_config: assert property (p_config)
    else $error("configuration allowed while not stopped");
  property p_fstop;
    $rose(fail_to_stop) |-> !engine_at_rest;
  endproperty
  a_fstop: assert property (p_fstop)
    else $error("fail to stop with engine at rest");
  property p_start;
    $rose(fuel_relay) |-> $past(pins.btn_start, 2) || $past(pins.btn_start, 3);
  endproperty
  a_start: assert property (p_start)
    else $error("fuel relay energised without start press");
  c_fire: cover property ($rose(fault_holdoff));
  c_fts: cover property ($rose(fail_to_start));
  c_fstop: cover property ($rose(fail_to_stop));
  c_load: cover property ($rose(gen_load));
endmodule
bind gms_sequencer gms_checker chk (.clock(clock), .sys_rst(sys_rst), .pins(pins),
  .led_stop(led_stop), .led_manual(led_manual), .led_test(led_test), .led_auto(led_auto),
  .fuel_relay(fuel_relay), .starter(starter), .gen_load(gen_load),
  .speed_detect(speed_detect), .fault_holdoff(fault_holdoff),
  .engine_at_rest(engine_at_rest), .config_allowed(config_allowed),
  .fail_to_start(fail_to_start), .fail_to_stop(fail_to_stop));

// [bench/gms_engine_model.sv]
`timescale 1ns/10ps
module gms_engine_model #(
  parameter int FIRE_CYC = 6,
  parameter int COAST_CYC = 10
) (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Drives from the controller
  input wire logic fuel_relay,
  input wire logic starter,
  // Scenario knobs
  input wire logic will_fire,
  input wire logic stuck,
  // Engine state
  output logic moving
);
  int cnt;
  // Stuck models a jammed fuel rack: the engine keeps turning with fuel cut
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      moving <= 1'b0;
      cnt <= 0;
    end else if (!moving) begin
      cnt <= (starter && fuel_relay && will_fire) ? cnt + 1 : 0;
      if (cnt == FIRE_CYC) moving <= 1'b1;
    end else begin
      cnt <= (fuel_relay || stuck) ? 0 : cnt + 1;
      if (cnt == COAST_CYC) moving <= 1'b0;
    end
  end
endmodule

// [bench/testbench.sv]
`timescale 1ns/10ps
module testbench import gms_pkg::*; ;
  localparam int B_STOP = 33, B_MAN = 32, B_TEST = 31, B_AUTO = 30, B_START = 29;
  localparam int B_XFER = 28, B_OPEN = 27, B_LOCK = 26, B_INH = 25, B_MF = 22, B_GA = 18;
  logic clock = 1'b0, sys_rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic [7:0] haddr = 8'h00, c;
  logic [1:0] htrans = 2'h0;
  logic [31:0] hwdata = 32'h0, hrdata, q, m;
  logic hreadyout, hresp, moving, will_fire = 1'b0, stuck = 1'b0;
  logic [33:0] pv = 34'h0;
  logic [4:0] mask = 5'h00;
  logic led_stop, led_manual, led_test, led_auto, fuel_relay, starter, ecu_power;
  logic gen_load, mains_load, fault_holdoff, speed_detect, engine_at_rest;
  logic config_allowed, power_save, fail_to_start, fail_to_stop;
  logic [7:0] alarm_latched, w;
  gms_pins_t pins;
  int mismatches = 0, total_checks = 0, cranks = 0, i;
  int bt[4] = '{B_MAN, B_TEST, B_AUTO, B_STOP};
  logic [3:0] le[4] = '{4'b0100, 4'b0010, 4'b0001, 4'b1000};
  int src[5] = '{24, 23, 22, 20, 19};
  logic [31:0] rv[6] = '{{20'h0, CTRL_RST}, {16'h0, CRANK_RST}, {16'h0, REST_RST},
    {16'h0, SAFETY_RST}, {16'h0, FSTOP_RST}, {16'h0, PSAVE_RST}};
  // Short timers keep the run small with a 4-cycle ms tick
  logic [31:0] cv[6] = '{32'h200, 32'h3, 32'h2, 32'h3, 32'h8, 32'hA};
  assign pins = {pv[33:17], {5{~moving}} & ~mask, moving, pv[10:0]};
  assign w = {!fuel_relay, power_save, engine_at_rest, fault_holdoff, gen_load,
    fail_to_stop, fail_to_start, hreadyout};
  always #12.5 clock = ~clock;
  always @(posedge starter) cranks++;
  gms_sequencer #(.TICK_DIV(4), .ATT_W(4)) dut (.clock(clock), .sys_rst(sys_rst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .pins(pins), .led_stop(led_stop), .led_manual(led_manual),
    .led_test(led_test), .led_auto(led_auto), .fuel_relay(fuel_relay), .starter(starter),
    .ecu_power(ecu_power), .gen_load(gen_load), .mains_load(mains_load),
    .fault_holdoff(fault_holdoff), .speed_detect(speed_detect),
    .engine_at_rest(engine_at_rest), .config_allowed(config_allowed),
    .power_save(power_save), .fail_to_start(fail_to_start), .fail_to_stop(fail_to_stop),
    .alarm_latched(alarm_latched));
  gms_engine_model eng (.clock(clock), .sys_rst(sys_rst), .fuel_relay(fuel_relay),
    .starter(starter), .will_fire(will_fire), .stuck(stuck), .moving(moving));
  task end_of_test;
    $display("Checks %0d, mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clock);
  endtask
  task await(input int b, input int lim);
    int k;
    for (k = 0; k < lim; k++) begin
      @(posedge clock);
      if (w[b] === 1'b1) break;
    end
    if (k == lim) begin
      mismatches++;
      $display("[FAIL] %0t wait %0d timed out", $time, b);
      end_of_test();
    end
  endtask
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= a;
    await(0, 20);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    await(0, 20);
    q = hrdata;
  endtask
  task press(input int b);
    pv[b] <= 1'b1;
    cyc(4);
    pv[b] <= 1'b0;
    cyc(4);
  endtask
  initial begin
    q = $urandom(19173);
    pv[21] = 1'b1;
    cyc(3);
    sys_rst <= 1'b0;
    cyc(2);
    chk({led_stop, led_manual, led_test, led_auto}, 4'b1000);
    for (i = 0; i < 6; i++) begin
      bus(1'b0, 8'(i * 4), 32'h0);
      chk(q, rv[i]);
    end
    bus(1'b1, OFS_STATUS, 32'hFFFFFFFF);
    bus(1'b0, OFS_STATUS, 32'h0);
    chk(q[10:0], {SEQ_IDLE, MODE_STOP});
    bus(1'b0, 8'h3C, 32'h0);
    chk(q, 32'h0);
    chk({hresp, hreadyout}, 2'b01);
    for (i = 0; i < 6; i++) bus(1'b1, 8'(i * 4), cv[i]);
    $display("Test registers done");
    press(B_START);
    chk({ecu_power, fuel_relay, starter}, 3'b100);
    pv[B_LOCK] <= 1'b1;
    cyc(3);
    press(B_MAN);
    chk({led_stop, led_manual, led_test, led_auto}, 4'b1000);
    pv[B_LOCK] <= 1'b0;
    cyc(3);
    for (i = 0; i < 4; i++) begin
      press(bt[i]);
      chk({led_stop, led_manual, led_test, led_auto}, le[i]);
    end
    $display("Test modes done");
    pv[7:0] <= 8'($urandom);
    press(B_MAN);
    cranks = 0;
    press(B_START);
    await(1, 800);
    chk({starter, fuel_relay, 6'(cranks)}, 8'h02);
    c = 8'($urandom);
    pv[7:0] <= c;
    cyc(4);
    press(B_STOP);
    chk({fail_to_start, alarm_latched & ~c}, 9'h0);
    chk(config_allowed, 1'b1);
    $display("Test fail to start done");
    will_fire <= 1'b1;
    press(B_MAN);
    press(B_START);
    chk(fuel_relay, 1'b1);
    await(4, 100);
    chk(starter, 1'b0);
    press(B_XFER);
    chk(gen_load, 1'b0);
    pv[B_GA] <= 1'b1;
    press(B_XFER);
    chk(gen_load, 1'b1);
    press(B_OPEN);
    chk(gen_load, 1'b0);
    for (i = 0; i < 5; i++) begin
      pv[src[i]] <= 1'b1;
      cyc(6);
      chk(gen_load, 1'b1);
      pv[src[i]] <= 1'b0;
      cyc(6);
      chk(gen_load, 1'b1);
      press(B_OPEN);
      chk(gen_load, 1'b0);
    end
    press(B_XFER);
    press(B_STOP);
    chk({gen_load, fuel_relay}, 2'b00);
    await(5, 200);
    $display("Test manual run done");
    press(B_TEST);
    press(B_START);
    await(3, 200);
    press(B_OPEN);
    chk(gen_load, 1'b1);
    pv[B_INH] <= 1'b1;
    cyc(5);
    chk(gen_load, 1'b0);
    pv[B_INH] <= 1'b0;
    press(B_AUTO);
    chk({led_auto, fuel_relay}, 2'b11);
    stuck <= 1'b1;
    press(B_STOP);
    await(2, 300);
    chk(config_allowed, 1'b0);
    stuck <= 1'b0;
    await(5, 200);
    $display("Test test mode done");
    for (i = 0; i < 24; i++) begin
      m = (i < 5) ? (32'h1 << i) : ((i == 5) ? 32'h0 : $urandom);
      mask <= m[4:0];
      cyc(4);
      chk(engine_at_rest, m[4:0] == 5'h00);
    end
    mask <= 5'h00;
    bus(1'b1, OFS_CTRL, 32'h208);
    pv[B_MF] <= 1'b1;
    cyc(5);
    chk(mains_load, 1'b0);
    pv[B_MF] <= 1'b0;
    cyc(5);
    chk(mains_load, 1'b1);
    bus(1'b1, OFS_CTRL, 32'h210);
    await(6, 600);
    press(B_XFER);
    chk(power_save, 1'b0);
    $display("Test stop options done");
    bus(1'b1, OFS_CTRL, 32'h207);
    for (i = 0; i < 8; i++) begin
      pv[10:8] <= 3'(i);
      cyc(4);
      chk(speed_detect, i[2:1] != 2'b00);
    end
    $display("Test speed sources done");
    end_of_test();
  end
endmodule

// [rtl/gms_pkg.sv]
// Functional notes
// R1 - Panel lock blocks mode changes only
// R2 - Buttons select modes; lit indicator shows mode
// R3 - Stop mode drops load before engine stop
// R4 - Fail-to-stop alarm when stop timer expires
// R5 - At rest needs all five zero conditions
// R6 - Config upload only at rest in stop
// R7 - Entering stop clears latched alarms now cleared
// R8 - Stop mode ignores start signals
// R9 - Immediate dropout follows mains in stop mode
// R10 - Idle stop mode enters power save
// R11 - Start in stop powers ECU only
// R12 - Manual/test start immediately, never automatically
// R13 - Each attempt energises fuel and starter
// R14 - Crank rest between attempts, then fail-to-start
// R15 - Release starter on firing from speed sources
// R16 - Oil pressure may release starter only
// R17 - Safety-on delay holds off listed faults
// R18 - No load transfer before generator available
// R19 - Manual loads only on loading request
// R20 - Test mode loads once generator available
// R21 - Load stays until open, mode, inhibit; open drops load in manual only
// R22 - Stop press drops load, stops at once
// R23 - Auto press hands control to auto mode
// R24 - One mode active; reset into stop mode
package gms_pkg;

  localparam int CLK_PERIOD_NS = 25;
  localparam int TICK_PERIOD_NS = 1000000;
  localparam int TICK_CYCLES = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CRANK = 8'h04;
  localparam logic [7:0] OFS_REST = 8'h08;
  localparam logic [7:0] OFS_SAFETY = 8'h0C;
  localparam logic [7:0] OFS_FSTOP = 8'h10;
  localparam logic [7:0] OFS_PSAVE = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_ALARM = 8'h1C;

  localparam int CTRL_MPU_EN = 0;
  localparam int CTRL_ECU_EN = 1;
  localparam int CTRL_OIL_EN = 2;
  localparam int CTRL_DROPOUT_EN = 3;
  localparam int CTRL_PSAVE_EN = 4;
  localparam int CTRL_ATT_LSB = 8;

  localparam logic [11:0] CTRL_RST = 12'h300;
  localparam logic [15:0] CRANK_RST = 16'h2710;
  localparam logic [15:0] REST_RST = 16'h2710;
  localparam logic [15:0] SAFETY_RST = 16'h2710;
  localparam logic [15:0] FSTOP_RST = 16'h7530;
  localparam logic [15:0] PSAVE_RST = 16'hEA60;

  typedef enum logic [3:0] {
    MODE_STOP = 4'h1,
    MODE_MANUAL = 4'h2,
    MODE_TEST = 4'h4,
    MODE_AUTO = 4'h8
  } gms_mode_t;

  typedef enum logic [6:0] {
    SEQ_IDLE = 7'h01,
    SEQ_CRANK = 7'h02,
    SEQ_REST = 7'h04,
    SEQ_SAFETY = 7'h08,
    SEQ_RUN = 7'h10,
    SEQ_STOPPING = 7'h20,
    SEQ_FAILED = 7'h40
  } gms_seq_t;

  typedef struct packed {
    logic btn_stop;
    logic btn_manual;
    logic btn_test;
    logic btn_auto;
    logic btn_start;
    logic btn_transfer;
    logic btn_open;
    logic panel_lock;
    logic load_inhibit;
    logic remote_on_load;
    logic aux_mains_fail;
    logic mains_fail;
    logic mains_avail;
    logic sched_on_load;
    logic balance_req;
    logic gen_avail;
    logic comms_active;
    logic ecu_speed_zero;
    logic gen_volt_zero;
    logic gen_freq_zero;
    logic chg_volt_zero;
    logic oil_low;
    logic fire_freq;
    logic fire_mpu;
    logic fire_ecu;
    logic oil_rising;
    logic [7:0] alarm_cause;
  } gms_pins_t;

endpackage

// [rtl/gms_sequencer.sv]
`timescale 1ns/10ps
module gms_sequencer import gms_pkg::*; #(
  parameter int TICK_DIV = TICK_CYCLES,
  parameter int ATT_W = 4
) (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Panel and engine pins, asynchronous
  input wire gms_pins_t pins,
  // Mode indicators
  output logic led_stop,
  output logic led_manual,
  output logic led_test,
  output logic led_auto,
  // Engine and load drives
  output logic fuel_relay,
  output logic starter,
  output logic ecu_power,
  output logic gen_load,
  output logic mains_load,
  // Status
  output logic fault_holdoff,
  output logic speed_detect,
  output logic engine_at_rest,
  output logic config_allowed,
  output logic power_save,
  output logic fail_to_start,
  output logic fail_to_stop,
  output logic [7:0] alarm_latched
);

  gms_pins_t meta_reg;
  gms_pins_t pin_reg;
  gms_pins_t prev_reg;
  gms_mode_t mode_reg;
  gms_mode_t mode_next;
  gms_seq_t seq_reg;
  gms_seq_t seq_next;
  logic [11:0] ctrl_reg;
  logic [15:0] crank_reg;
  logic [15:0] rest_reg;
  logic [15:0] safety_reg;
  logic [15:0] fstop_reg;
  logic [15:0] psave_reg;
  logic [31:0] tick_cnt_reg;
  logic tick;
  logic [15:0] timer_reg;
  logic [15:0] idle_reg;
  logic [ATT_W-1:0] attempt_reg;
  logic [ATT_W-1:0] attempt_max;
  logic gen_load_reg;
  logic mains_load_reg;
  logic ecu_ovr_reg;
  logic psave_reg_on;
  logic fts_reg;
  logic ftp_reg;
  logic [7:0] alarm_reg;
  logic enter_stop;
  logic timer_done;
  logic fired;
  logic at_rest;
  logic any_press;
  logic load_req;
  logic wr_pend_reg;
  logic [7:0] wr_addr_reg;
  logic [31:0] rdata_reg;
  logic [31:0] status_word;

  function automatic logic press(input logic now_v, input logic old_v);
    press = now_v & ~old_v;
  endfunction

  // Both sync stages hold the whole pin bundle; pin_reg and its prev_reg copy are read
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      meta_reg <= '0;
      pin_reg <= '0;
      prev_reg <= '0;
    end else begin
      meta_reg <= pins;
      pin_reg <= meta_reg;
      prev_reg <= pin_reg;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      tick_cnt_reg <= '0;
    end else if (tick) begin
      tick_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
    end
  end
  assign tick = (tick_cnt_reg == 32'(TICK_DIV - 1));

  assign at_rest = pin_reg.ecu_speed_zero & pin_reg.gen_volt_zero & pin_reg.gen_freq_zero
                 & pin_reg.chg_volt_zero & pin_reg.oil_low; // R5
  assign speed_detect = pin_reg.fire_freq | (ctrl_reg[CTRL_MPU_EN] & pin_reg.fire_mpu)
                      | (ctrl_reg[CTRL_ECU_EN] & pin_reg.fire_ecu); // R15
  assign fired = speed_detect | (ctrl_reg[CTRL_OIL_EN] & pin_reg.oil_rising); // R16
  assign any_press = |({pin_reg.btn_stop, pin_reg.btn_manual, pin_reg.btn_test,
                        pin_reg.btn_auto, pin_reg.btn_start, pin_reg.btn_transfer,
                        pin_reg.btn_open} & ~{prev_reg.btn_stop, prev_reg.btn_manual,
                        prev_reg.btn_test, prev_reg.btn_auto, prev_reg.btn_start,
                        prev_reg.btn_transfer, prev_reg.btn_open});

  // Stop wins when several mode buttons rise together
  always_comb begin
    mode_next = mode_reg;
    if (!pin_reg.panel_lock) begin // R1
      if (press(pin_reg.btn_stop, prev_reg.btn_stop)) begin
        mode_next = MODE_STOP; // R2
      end else if (press(pin_reg.btn_auto, prev_reg.btn_auto)) begin
        mode_next = MODE_AUTO; // R23
      end else if (press(pin_reg.btn_manual, prev_reg.btn_manual)) begin
        mode_next = MODE_MANUAL;
      end else if (press(pin_reg.btn_test, prev_reg.btn_test)) begin
        mode_next = MODE_TEST;
      end
    end
  end
  assign enter_stop = (mode_next == MODE_STOP) && (mode_reg != MODE_STOP);

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      mode_reg <= MODE_STOP; // R24
    end else begin
      mode_reg <= mode_next; // R2
    end
  end

  assign attempt_max = ctrl_reg[CTRL_ATT_LSB +: ATT_W];
  assign timer_done = (timer_reg == 16'h0000);

  always_comb begin
    seq_next = seq_reg;
    case (seq_reg)
      SEQ_IDLE: begin
        // Auto mode has no start path; only manual and test crank
        if ((mode_reg == MODE_MANUAL || mode_reg == MODE_TEST)
            && press(pin_reg.btn_start, prev_reg.btn_start)) begin // R8
          seq_next = SEQ_CRANK; // R12
        end
      end
      SEQ_CRANK: begin
        if (mode_reg == MODE_STOP) begin
          seq_next = SEQ_STOPPING; // R22
        end else if (fired) begin
          seq_next = SEQ_SAFETY; // R15
        end else if (timer_done) begin
          seq_next = (attempt_reg >= attempt_max) ? SEQ_FAILED : SEQ_REST; // R14
        end
      end
      SEQ_REST: begin
        if (mode_reg == MODE_STOP) begin
          seq_next = SEQ_STOPPING;
        end else if (timer_done) begin
          seq_next = SEQ_CRANK; // R14
        end
      end
      SEQ_SAFETY: begin
        if (mode_reg == MODE_STOP && !gen_load_reg) begin
          seq_next = SEQ_STOPPING; // R3
        end else if (timer_done) begin
          seq_next = SEQ_RUN; // R17
        end
      end
      SEQ_RUN: begin
        if (mode_reg == MODE_STOP && !gen_load_reg) begin
          seq_next = SEQ_STOPPING; // R3
        end
      end
      SEQ_STOPPING: begin
        if (at_rest) begin
          seq_next = SEQ_IDLE;
        end
      end
      SEQ_FAILED: begin
        if (mode_reg == MODE_STOP) begin
          seq_next = SEQ_IDLE;
        end
      end
      default: seq_next = SEQ_IDLE;
    endcase
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      seq_reg <= SEQ_IDLE;
    end else begin
      seq_reg <= seq_next;
    end
  end

  // One countdown in ms, reloaded on every state change
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      timer_reg <= '0;
    end else if (seq_next != seq_reg) begin
      case (seq_next)
        SEQ_CRANK: timer_reg <= crank_reg;
        SEQ_REST: timer_reg <= rest_reg; // R14
        SEQ_SAFETY: timer_reg <= safety_reg; // R17
        SEQ_STOPPING: timer_reg <= fstop_reg; // R4
        default: timer_reg <= '0;
      endcase
    end else if (tick && !timer_done) begin
      timer_reg <= timer_reg - 16'h0001;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      attempt_reg <= '0;
    end else if (seq_reg == SEQ_IDLE && seq_next == SEQ_CRANK) begin
      attempt_reg <= ATT_W'(1);
    end else if (seq_reg == SEQ_REST && seq_next == SEQ_CRANK) begin
      attempt_reg <= attempt_reg + ATT_W'(1);
    end
  end

  assign fuel_relay = (seq_reg == SEQ_CRANK) || (seq_reg == SEQ_REST)
                   || (seq_reg == SEQ_SAFETY) || (seq_reg == SEQ_RUN); // R13
  assign starter = (seq_reg == SEQ_CRANK); // R13
  assign fault_holdoff = (seq_reg == SEQ_SAFETY); // R17

  // Loading requests honoured only in manual
  assign load_req = press(pin_reg.btn_transfer, prev_reg.btn_transfer) | pin_reg.mains_fail
                  | pin_reg.remote_on_load | pin_reg.aux_mains_fail | pin_reg.sched_on_load
                  | pin_reg.balance_req; // R19

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      gen_load_reg <= 1'b0;
    end else if (mode_reg == MODE_STOP || mode_reg == MODE_AUTO || pin_reg.load_inhibit
                 || !pin_reg.gen_avail) begin
      gen_load_reg <= 1'b0; // R21
    end else if (mode_reg == MODE_MANUAL
                 && press(pin_reg.btn_open, prev_reg.btn_open)) begin
      gen_load_reg <= 1'b0; // R21
    end else if (seq_reg == SEQ_RUN || seq_reg == SEQ_SAFETY) begin
      if (mode_reg == MODE_TEST) begin
        gen_load_reg <= 1'b1; // R20
      end else if (load_req) begin
        gen_load_reg <= 1'b1; // R19
      end
    end
  end
  assign gen_load = gen_load_reg & pin_reg.gen_avail; // R18

  // Mains switch opens one cycle after the generator switch closes and stays open while it is closed
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      mains_load_reg <= 1'b0;
    end else if (gen_load_reg) begin
      mains_load_reg <= 1'b0;
    end else if (mode_reg == MODE_STOP && ctrl_reg[CTRL_DROPOUT_EN]) begin
      mains_load_reg <= pin_reg.mains_avail & ~pin_reg.mains_fail; // R9
    end else begin
      mains_load_reg <= 1'b1;
    end
  end
  assign mains_load = mains_load_reg;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ecu_ovr_reg <= 1'b0;
    end else if (mode_reg != MODE_STOP) begin
      ecu_ovr_reg <= 1'b0;
    end else if (press(pin_reg.btn_start, prev_reg.btn_start)) begin
      ecu_ovr_reg <= 1'b1; // R11
    end
  end
  assign ecu_power = ecu_ovr_reg | fuel_relay; // R8

  // Cause present wins over the clear on stop entry
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      alarm_reg <= '0;
    end else if (enter_stop) begin
      alarm_reg <= alarm_reg & pin_reg.alarm_cause; // R7
    end else begin
      alarm_reg <= alarm_reg | pin_reg.alarm_cause;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      fts_reg <= 1'b0;
    end else if (seq_next == SEQ_FAILED && seq_reg != SEQ_FAILED) begin
      fts_reg <= 1'b1; // R14
    end else if (enter_stop) begin
      fts_reg <= 1'b0; // R7
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ftp_reg <= 1'b0;
    end else if (seq_reg == SEQ_STOPPING && timer_done && !at_rest) begin
      ftp_reg <= 1'b1; // R4
    end else if (enter_stop && at_rest) begin
      ftp_reg <= 1'b0; // R7
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      idle_reg <= '0;
      psave_reg_on <= 1'b0;
    end else if (any_press || pin_reg.comms_active || mode_reg != MODE_STOP
                 || !ctrl_reg[CTRL_PSAVE_EN]) begin
      idle_reg <= '0;
      psave_reg_on <= 1'b0; // R10
    end else if (idle_reg >= psave_reg) begin
      psave_reg_on <= 1'b1; // R10
    end else if (tick) begin
      idle_reg <= idle_reg + 16'h0001;
    end
  end

  assign led_stop = (mode_reg == MODE_STOP); // R2
  assign led_manual = (mode_reg == MODE_MANUAL);
  assign led_test = (mode_reg == MODE_TEST);
  assign led_auto = (mode_reg == MODE_AUTO);
  assign engine_at_rest = at_rest;
  assign config_allowed = at_rest & (mode_reg == MODE_STOP); // R6
  assign power_save = psave_reg_on;
  assign fail_to_start = fts_reg;
  assign fail_to_stop = ftp_reg;
  assign alarm_latched = alarm_reg;

  // Zero-wait slave; reads are captured in the address phase
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_reg;
  assign status_word = {4'h0, 4'(attempt_reg), 2'h0, gen_load_reg, ftp_reg, fts_reg,
                        psave_reg_on, config_allowed, at_rest, 5'h00, seq_reg, mode_reg};

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= '0;
      rdata_reg <= '0;
    end else begin
      wr_pend_reg <= 1'b0;
      if (hsel && htrans[1] && hready) begin
        wr_pend_reg <= hwrite;
        wr_addr_reg <= haddr;
        if (!hwrite) begin
          if (haddr == OFS_CTRL) begin
            rdata_reg <= {20'h00000, ctrl_reg};
          end else if (haddr == OFS_CRANK) begin
            rdata_reg <= {16'h0000, crank_reg};
          end else if (haddr == OFS_REST) begin
            rdata_reg <= {16'h0000, rest_reg};
          end else if (haddr == OFS_SAFETY) begin
            rdata_reg <= {16'h0000, safety_reg};
          end else if (haddr == OFS_FSTOP) begin
            rdata_reg <= {16'h0000, fstop_reg};
          end else if (haddr == OFS_PSAVE) begin
            rdata_reg <= {16'h0000, psave_reg};
          end else if (haddr == OFS_STATUS) begin
            rdata_reg <= status_word;
          end else if (haddr == OFS_ALARM) begin
            rdata_reg <= {24'h000000, alarm_reg};
          end else begin
            rdata_reg <= '0;
          end
        end
      end
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_reg <= CTRL_RST;
      crank_reg <= CRANK_RST;
      rest_reg <= REST_RST;
      safety_reg <= SAFETY_RST;
      fstop_reg <= FSTOP_RST;
      psave_reg <= PSAVE_RST;
    end else if (wr_pend_reg) begin
      if (wr_addr_reg == OFS_CTRL) begin
        ctrl_reg <= hwdata[11:0];
      end else if (wr_addr_reg == OFS_CRANK) begin
        crank_reg <= hwdata[15:0];
      end else if (wr_addr_reg == OFS_REST) begin
        rest_reg <= hwdata[15:0];
      end else if (wr_addr_reg == OFS_SAFETY) begin
        safety_reg <= hwdata[15:0];
      end else if (wr_addr_reg == OFS_FSTOP) begin
        fstop_reg <= hwdata[15:0];
      end else if (wr_addr_reg == OFS_PSAVE) begin
        psave_reg <= hwdata[15:0];
      end
    end
  end

endmodule
